// file: verilog/crs_core.sv
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1 - Port suspend stops host bus traffic
// R2 - Clamp enable clamps cross-rail signals
// R3 - Host session end follows ordered sequence
// R4 - Host SRP restarts transceiver clock, flags
// R5 - After SRP, software restores in order
// R6 - Port power: detect connect, drive reset
// R7 - Device resume must persist 75 cycles
// R8 - Software sets resume period 4 at 32k
// R9 - SE0 persistence starts high-speed handshake
// R10 - Low rate clock held until restored
// R11 - Device deep sleep entry in order
// R12 - Suspended device flags bus resume
// R13 - Device resume exit steps in order
// R14 - Remote wakeup restore then write control
// R15 - Wait 1 ms, clear all status
// R16 - Clear wakeup signal after 1-15 ms
// R17 - Device flags bus suspend first
// R18 - Device flags new session, later reset
// R19 - Gate bus clock while suspended
// R20 - Clearing stop and gate restarts clock
// R21 - Host resume held at least 20 ms
// R22 - Host remote wakeup flags, sets resume
// R23 - Two transceiver clocks between steps
// R24 - Control bits hold until software writes
// R25 - Detection runs on low rate clock
module crs_core #(
    parameter logic [19:0] SUSP_TICKS = crs_pkg::SUSP_TICKS,
    parameter logic [19:0] HRST_TICKS = crs_pkg::HRST_TICKS,
    parameter logic [19:0] CONN_TICKS = crs_pkg::CONN_TICKS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic dp_in,
    input wire logic dm_in,
    input wire logic vbus_valid,
    output logic dp_o,
    output logic dp_oe,
    output logic dm_o,
    output logic dm_oe,
    output logic vbus_drive,
    output logic sof_en,
    output logic phy_suspend_n,
    output logic power_clamp,
    output logic pd_module_rst,
    output logic bus_clk_en,
    output logic hs_detect_start
);
    typedef enum logic [4:0] {
        HP_OFF = 5'h01,
        HP_CONN = 5'h02,
        HP_RST = 5'h04,
        HP_RUN = 5'h08,
        HP_SUSP = 5'h10
    } crs_port_e;

    typedef struct packed {
        crs_port_e port;
        logic [3:0] pcgc;
        logic [2:0] hprt;
        logic [1:0] dctl;
        logic host;
        logic lf;
        logic [7:0] rv;
        logic [6:0] sts;
        logic [31:0] rdata;
        logic wake;
        logic dsusp;
        logic [4:0] hit_d;
        logic vb_d;
        logic dpo;
        logic dmo;
        logic oe;
        logic sof;
        logic phy_n;
        logic bclk;
        logic hs_go;
        logic sdp1;
        logic sdp2;
        logic sdm1;
        logic sdm2;
        logic svb1;
        logic svb2;
    } crs_core_s;

    crs_core_s q;
    crs_core_s next_q;
    logic dp, dm, vb, j_st, k_st, se0, susp_now;
    logic [4:0] c;
    logic [4:0] hit;
    logic [4:0] rise;
    logic [19:0] th [5];
    logic [6:0] ev;
    logic ev_conn;

    function automatic logic [19:0] crs_th(input logic lfs, input logic [7:0] rv,
                                           input logic [19:0] fast);
        crs_th = lfs ? {12'h000, rv} : fast;
    endfunction

    // ----------------------------------------
    // Core tick and persistence timers
    // ----------------------------------------
    crs_tick_if tk();

    // Ticks come from mclk, so detection keeps running with the PHY clock stopped
    // R25 detection never stopped
    crs_tick_gen u_tick (
        .mclk(mclk),
        .nrst(nrst),
        .lf_sel(q.lf),
        .tk(tk.src)
    );

    for (genvar i = 0; i < 5; i++) begin : g_tmr
        crs_line_timer u_tmr (
            .mclk(mclk),
            .nrst(nrst),
            .tk(tk.dst),
            .cond(c[i]),
            .thresh(th[i]),
            .hit(hit[i])
        );
    end

    assign dp = q.sdp2;
    assign dm = q.sdm2;
    assign vb = q.svb2;
    assign j_st = dp & !dm;
    assign k_st = !dp & dm;
    assign se0 = !dp & !dm;
    assign rise = hit & ~q.hit_d;
    assign susp_now = q.host ? (q.hprt[crs_pkg::B_PSUSP] | !q.hprt[crs_pkg::B_PPWR])
                             : (q.dsusp | !vb);

    // K only counts when we are not driving it ourselves
    assign c[0] = k_st & susp_now & !q.oe;
    assign c[1] = !q.host & se0 & vb;
    assign c[2] = !q.host & vb & j_st;
    assign c[3] = q.host & dp & !q.oe;
    assign c[4] = q.host & (q.port == HP_RST);
    // R7 resume validation period
    assign th[0] = crs_th(q.lf, q.rv, crs_pkg::RESUME_CYC);
    // R9 reset SE0 period
    assign th[1] = crs_th(q.lf, q.rv, crs_pkg::SE0_CYC);
    assign th[2] = SUSP_TICKS;
    assign th[3] = CONN_TICKS;
    assign th[4] = HRST_TICKS;

    // ----------------------------------------
    // Detected events
    // ----------------------------------------
    // R17 idle bus means suspend
    assign ev[crs_pkg::S_SUSP] = !q.host & rise[2];
    // R12 resume while suspended
    assign ev[crs_pkg::S_RES] = !q.host & rise[0];
    // R22 remote wakeup seen
    assign ev[crs_pkg::S_RWK] = q.host & rise[0];
    // R4 data line pulsing
    assign ev[crs_pkg::S_SRP] = q.host & !q.hprt[crs_pkg::B_PPWR] & rise[3];
    // R18 session valid rising
    assign ev[crs_pkg::S_NSES] = !q.host & vb & !q.vb_d;
    assign ev[crs_pkg::S_BRST] = !q.host & rise[1];
    // R6 attach while powered
    assign ev_conn = q.host & q.hprt[crs_pkg::B_PPWR] & rise[3] & (q.port == HP_CONN);
    assign ev[crs_pkg::S_CONN] = ev_conn;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_q = q;
        next_q.sdp1 = dp_in;
        next_q.sdp2 = q.sdp1;
        next_q.sdm1 = dm_in;
        next_q.sdm2 = q.sdm1;
        next_q.svb1 = vbus_valid;
        next_q.svb2 = q.svb1;
        next_q.hit_d = hit;
        next_q.vb_d = vb;
        next_q.rdata = 32'h0000_0000;
        next_q.hs_go = 1'b0;
        // R24 controls change by write only, except port resume, which remote wakeup also sets
        if (reg_wr) begin
            case (reg_addr)
                crs_pkg::OFS_PCGC: begin
                    next_q.pcgc = reg_wdata[3:0];
                end
                crs_pkg::OFS_HPRT: begin
                    next_q.hprt = reg_wdata[2:0];
                end
                crs_pkg::OFS_DCTL: begin
                    next_q.dctl = reg_wdata[1:0];
                end
                crs_pkg::OFS_CFG: begin
                    next_q.host = reg_wdata[crs_pkg::B_HOST];
                    next_q.lf = reg_wdata[crs_pkg::B_LF];
                    next_q.rv = reg_wdata[crs_pkg::RV_LSB +: 8];
                end
                crs_pkg::OFS_STS: begin
                    next_q.sts = q.sts & ~reg_wdata[6:0];
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                crs_pkg::OFS_PCGC: next_q.rdata = {28'h0, q.pcgc};
                crs_pkg::OFS_HPRT: next_q.rdata = {29'h0, q.hprt};
                crs_pkg::OFS_DCTL: next_q.rdata = {30'h0, q.dctl};
                crs_pkg::OFS_CFG: next_q.rdata = {16'h0, q.rv, 6'h0, q.lf, q.host};
                crs_pkg::OFS_STS: next_q.rdata = {25'h0, q.sts};
                crs_pkg::OFS_LINE: next_q.rdata = {24'h0, q.port, vb, dm, dp};
                default: next_q.rdata = 32'h0000_0000;
            endcase
        end
        // Set wins over a write-one clear in the same cycle
        next_q.sts = next_q.sts | ev;
        // R22 core sets port resume
        if (ev[crs_pkg::S_RWK]) begin
            next_q.hprt[crs_pkg::B_PRES] = 1'b1;
        end
        // R9 start high-speed handshake
        if (ev[crs_pkg::S_BRST]) begin
            next_q.hs_go = 1'b1;
        end
        if (ev[crs_pkg::S_SUSP]) begin
            next_q.dsusp = 1'b1;
        end else if (ev[crs_pkg::S_RES] | ev[crs_pkg::S_BRST] | q.host) begin
            next_q.dsusp = 1'b0;
        end
        // R4 wake restarts PHY clock
        if (!next_q.pcgc[crs_pkg::B_STOP]) begin
            next_q.wake = 1'b0;
        end else if (|ev[crs_pkg::S_NSES:crs_pkg::S_RES]) begin
            next_q.wake = 1'b1;
        end
        // R20 clock runs once stop clears
        next_q.phy_n = !next_q.pcgc[crs_pkg::B_STOP] | next_q.wake;
        // R19 gate only in low power
        next_q.bclk = !(next_q.pcgc[crs_pkg::B_GATE] & susp_now);
        // R6 host port sequence
        case (q.port)
            HP_OFF: begin
                if (q.host) begin
                    next_q.port = HP_CONN;
                end
            end
            HP_CONN: begin
                if (ev_conn) begin
                    next_q.port = HP_RST;
                end
            end
            HP_RST: begin
                if (hit[4]) begin
                    next_q.port = HP_RUN;
                end
            end
            HP_RUN: begin
                if (next_q.hprt[crs_pkg::B_PSUSP]) begin
                    next_q.port = HP_SUSP;
                end
            end
            HP_SUSP: begin
                if (!next_q.hprt[crs_pkg::B_PSUSP]) begin
                    next_q.port = HP_RUN;
                end
            end
            default: begin
                next_q.port = HP_OFF;
            end
        endcase
        if (!next_q.host || !next_q.hprt[crs_pkg::B_PPWR]) begin
            next_q.port = HP_OFF;
        end
        // Line drive: reset SE0, else K for resume or remote wakeup
        next_q.oe = 1'b0;
        next_q.dpo = 1'b0;
        next_q.dmo = 1'b0;
        if (next_q.host && (next_q.port == HP_RST)) begin
            next_q.oe = 1'b1;
        end else if (next_q.host && next_q.hprt[crs_pkg::B_PRES]) begin
            next_q.oe = 1'b1;
            next_q.dmo = 1'b1;
        end else if (!next_q.host && next_q.dctl[crs_pkg::B_RWAKE]) begin
            next_q.oe = 1'b1;
            next_q.dmo = 1'b1;
        end
        // R1 suspend stops frame traffic
        next_q.sof = next_q.host && (next_q.port == HP_RUN)
                     && !next_q.hprt[crs_pkg::B_PSUSP];
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.port <= HP_OFF;
            q.pcgc <= crs_pkg::PCGC_RST;
            q.hprt <= crs_pkg::HPRT_RST;
            q.dctl <= crs_pkg::DCTL_RST;
            q.rv <= crs_pkg::RV_RST;
            q.phy_n <= 1'b1;
            q.bclk <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = q.rdata;
    assign dp_o = q.dpo;
    assign dm_o = q.dmo;
    assign dp_oe = q.oe;
    assign dm_oe = q.oe;
    assign vbus_drive = q.host & q.hprt[crs_pkg::B_PPWR];
    assign sof_en = q.sof;
    assign phy_suspend_n = q.phy_n;
    // R2 clamp follows control
    assign power_clamp = q.pcgc[crs_pkg::B_CLAMP];
    assign pd_module_rst = q.pcgc[crs_pkg::B_PDRST];
    assign bus_clk_en = q.bclk;
    assign hs_detect_start = q.hs_go;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_SOF_OFF: assert property (@(posedge mclk) disable iff (!nrst) // R1
        q.hprt[crs_pkg::B_PSUSP] |-> !sof_en)
        else $error("frames sent while port suspended");
    AST_CLAMP_WR: assert property (@(posedge mclk) disable iff (!nrst) // R2
        (reg_wr && reg_addr == crs_pkg::OFS_PCGC)
        |=> power_clamp == $past(reg_wdata[crs_pkg::B_CLAMP]))
        else $error("clamp does not follow write");
    AST_SRP_WAKE: assert property (@(posedge mclk) disable iff (!nrst) // R4
        ev[crs_pkg::S_SRP] |=> phy_suspend_n && q.sts[crs_pkg::S_SRP])
        else $error("session request did not wake PHY");
    AST_CONN_RST: assert property (@(posedge mclk) disable iff (!nrst) // R6
        (ev_conn && !reg_wr) |=> (q.port == HP_RST) && dp_oe && !dp_o && !dm_o)
        else $error("no bus reset after connect");
    AST_HS_GO: assert property (@(posedge mclk) disable iff (!nrst) // R9
        ev[crs_pkg::S_BRST] |=> hs_detect_start ##1 !hs_detect_start)
        else $error("handshake start not one pulse");
    AST_RESUME: assert property (@(posedge mclk) disable iff (!nrst) // R12
        ev[crs_pkg::S_RES] |=> q.sts[crs_pkg::S_RES])
        else $error("resume not flagged");
    AST_SUSP: assert property (@(posedge mclk) disable iff (!nrst) // R17
        ev[crs_pkg::S_SUSP] |=> q.sts[crs_pkg::S_SUSP] && q.dsusp)
        else $error("suspend not flagged");
    AST_NSES: assert property (@(posedge mclk) disable iff (!nrst) // R18
        (!q.host && $rose(vb)) |=> q.sts[crs_pkg::S_NSES])
        else $error("new session not flagged");
    AST_GATE: assert property (@(posedge mclk) disable iff (!nrst) // R19
        !bus_clk_en |-> q.pcgc[crs_pkg::B_GATE])
        else $error("bus clock gated without control");
    AST_STOP_CLR: assert property (@(posedge mclk) disable iff (!nrst) // R20
        (reg_wr && reg_addr == crs_pkg::OFS_PCGC && !reg_wdata[crs_pkg::B_STOP])
        |=> phy_suspend_n)
        else $error("PHY clock not restarted");
    AST_RWK_PRES: assert property (@(posedge mclk) disable iff (!nrst) // R22
        ev[crs_pkg::S_RWK] |=> q.hprt[crs_pkg::B_PRES] && q.sts[crs_pkg::S_RWK])
        else $error("remote wakeup did not set port resume");
    AST_HOLD: assert property (@(posedge mclk) disable iff (!nrst) // R24
        !(reg_wr && reg_addr == crs_pkg::OFS_PCGC) |=> $stable(q.pcgc))
        else $error("control bits changed without write");
endmodule
`default_nettype wire

// file: verilog/crs_pkg.sv
`default_nettype none
package crs_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_PCGC = 8'h00;
    localparam logic [7:0] OFS_HPRT = 8'h04;
    localparam logic [7:0] OFS_DCTL = 8'h08;
    localparam logic [7:0] OFS_CFG = 8'h0c;
    localparam logic [7:0] OFS_STS = 8'h10;
    localparam logic [7:0] OFS_LINE = 8'h14;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int B_STOP = 0;
    localparam int B_GATE = 1;
    localparam int B_CLAMP = 2;
    localparam int B_PDRST = 3;
    localparam int B_PSUSP = 0;
    localparam int B_PRES = 1;
    localparam int B_PPWR = 2;
    localparam int B_RWAKE = 0;
    localparam int B_PGDONE = 1;
    localparam int B_HOST = 0;
    localparam int B_LF = 1;
    localparam int RV_LSB = 8;
    localparam int S_SUSP = 0;
    localparam int S_RES = 1;
    localparam int S_RWK = 2;
    localparam int S_SRP = 3;
    localparam int S_NSES = 4;
    localparam int S_BRST = 5;
    localparam int S_CONN = 6;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] PCGC_RST = 4'h0;
    localparam logic [2:0] HPRT_RST = 3'h0;
    localparam logic [1:0] DCTL_RST = 2'h0;
    localparam logic [7:0] RV_RST = 8'h04;
    // ----------------------------------------
    // Rates and counts
    // ----------------------------------------
    localparam longint MCLK_HZ = 125000000;
    localparam longint FAST_HZ = 48000000;
    localparam longint LF_HZ = 32000;
    localparam logic [23:0] INC_FAST = 24'((FAST_HZ << 24) / MCLK_HZ);
    localparam logic [23:0] INC_LF = 24'((LF_HZ << 24) / MCLK_HZ);
    localparam int FAST_KHZ = 48000;
    localparam logic [19:0] RESUME_CYC = 20'd75;
    localparam logic [19:0] SE0_CYC = 20'd120;
    localparam int SUSP_MS = 3;
    localparam int HRST_MS = 10;
    localparam int CONN_US = 100;
    localparam logic [19:0] SUSP_TICKS = 20'(SUSP_MS * FAST_KHZ);
    localparam logic [19:0] HRST_TICKS = 20'(HRST_MS * FAST_KHZ);
    localparam logic [19:0] CONN_TICKS = 20'(CONN_US * FAST_KHZ / 1000);
endpackage
`default_nettype wire

// file: verilog/crs_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface crs_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// file: verilog/crs_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module crs_tick_gen (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic lf_sel,
    crs_tick_if.src tk
);
    typedef struct packed {
        logic [23:0] acc;
        logic tick;
    } crs_tick_s;
    crs_tick_s q;
    crs_tick_s next_q;
    logic [24:0] sum;

    // Fractional divider: core rate is not a whole fraction of mclk
    always_comb begin
        next_q = q;
        // R10 rate follows software select
        sum = {1'b0, q.acc} + {1'b0, (lf_sel ? crs_pkg::INC_LF : crs_pkg::INC_FAST)};
        next_q.acc = sum[23:0];
        next_q.tick = sum[24];
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tk.tick = q.tick;

    AST_LF_SPACING: assert property (@(posedge mclk) disable iff (!nrst) // R10
        (q.tick && lf_sel && $past(lf_sel)) |=> !q.tick [*8])
        else $error("low rate ticks too close");
endmodule
`default_nettype wire

// file: verilog/crs_line_timer.sv
`timescale 1ns/100ps
`default_nettype none
module crs_line_timer (
    input wire logic mclk,
    input wire logic nrst,
    crs_tick_if.dst tk,
    input wire logic cond,
    input wire logic [19:0] thresh,
    output logic hit
);
    typedef struct packed {
        logic [19:0] cnt;
        logic hit;
    } crs_tmr_s;
    crs_tmr_s q;
    crs_tmr_s next_q;

    // Saturating count of core ticks while the condition persists
    always_comb begin
        next_q = q;
        if (!cond) begin
            next_q.cnt = '0;
        end else if (tk.tick && (q.cnt < thresh)) begin
            next_q.cnt = q.cnt + 20'd1;
        end
        next_q.hit = cond && (next_q.cnt >= thresh);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign hit = q.hit;

    AST_TMR_DROP: assert property (@(posedge mclk) disable iff (!nrst) // R7
        !cond |=> !hit)
        else $error("timer hit without held condition");
endmodule
`default_nettype wire

// file: dv/crs_usb_partner.sv
`timescale 1ns/100ps
`default_nettype none
// Far-end transceiver and cable, seen at the synchroniser inputs
module crs_usb_partner (
    input wire logic [1:0] st,
    input wire logic dp_o,
    input wire logic dp_oe,
    input wire logic dm_o,
    input wire logic dm_oe,
    output logic dp_in,
    output logic dm_in
);
    // st: 0 released, 1 J, 2 K, 3 SE0; released lines fall to pull-downs
    logic fdp;
    logic fdm;
    assign fdp = (st == 2'h1);
    assign fdm = (st == 2'h2);
    // Local drive wins over the far end, as the PHY sees its own drive
    assign dp_in = dp_oe ? dp_o : fdp;
    assign dm_in = dm_oe ? dm_o : fdm;
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [31:0] CFG0 = 32'(crs_pkg::RV_RST) << crs_pkg::RV_LSB;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic vbus_valid = 1'b0;
    logic [1:0] st = 2'h0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_v;
    logic dp_in, dm_in, dp_o, dp_oe, dm_o, dm_oe, vbus_drive, sof_en;
    logic phy_suspend_n, power_clamp, pd_module_rst, bus_clk_en, hs_detect_start;
    int fails = 0;
    int n_compared = 0;
    int hs_cnt = 0;

    crs_core #(.SUSP_TICKS(20'd20), .HRST_TICKS(20'd20), .CONN_TICKS(20'd10)) u_dut (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dp_in(dp_in), .dm_in(dm_in), .vbus_valid(vbus_valid),
        .dp_o(dp_o), .dp_oe(dp_oe), .dm_o(dm_o), .dm_oe(dm_oe),
        .vbus_drive(vbus_drive), .sof_en(sof_en), .phy_suspend_n(phy_suspend_n),
        .power_clamp(power_clamp), .pd_module_rst(pd_module_rst),
        .bus_clk_en(bus_clk_en), .hs_detect_start(hs_detect_start)
    );
    crs_usb_partner u_far (
        .st(st), .dp_o(dp_o), .dp_oe(dp_oe), .dm_o(dm_o), .dm_oe(dm_oe),
        .dp_in(dp_in), .dm_in(dm_in)
    );

    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (hs_detect_start === 1'b1) begin
            hs_cnt <= hs_cnt + 1;
        end
    end
    // ----------------------------------------
    // Bus access and checks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    function automatic int tk(input int n);
        return n * 125 / 48 + 3;
    endfunction
    task automatic line(input logic [1:0] s);
        @(posedge mclk);
        st <= s;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // Two transceiver clocks at the fast rate, not two mclk
        cyc(tk(2));
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rd_v = reg_rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chb(input string n, input logic e, input logic g);
        chk(n, 32'(e), 32'(g));
    endtask
    // Polls status until the bit shows or the poll limit runs out
    task automatic wsts(input int b, input int lim, input string n);
        int i;
        i = 0;
        rd(crs_pkg::OFS_STS);
        while (rd_v[b] !== 1'b1 && i < lim) begin
            i++;
            rd(crs_pkg::OFS_STS);
        end
        chb(n, 1'b1, rd_v[b]);
    endtask
    task automatic end_of_test();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chb("phy_suspend_n", 1'b1, phy_suspend_n);
        chb("bus_clk_en", 1'b1, bus_clk_en);
        rd(crs_pkg::OFS_CFG);
        chk("cfg", CFG0, rd_v);
        rd(8'h3c);
        chk("unmapped", 32'h0, rd_v);
    endtask
    task automatic t_pcgc();
        wr(crs_pkg::OFS_PCGC, 32'hf);
        cyc(40);
        chb("power_clamp", 1'b1, power_clamp);
        chb("pd_module_rst", 1'b1, pd_module_rst);
        chb("phy_suspend_n", 1'b0, phy_suspend_n);
        chb("bus_clk_en", 1'b0, bus_clk_en);
        wr(crs_pkg::OFS_PCGC, 32'hc);
        chb("phy_suspend_n", 1'b1, phy_suspend_n);
        chb("bus_clk_en", 1'b1, bus_clk_en);
        wr(crs_pkg::OFS_PCGC, 32'h0);
        chb("power_clamp", 1'b0, power_clamp);
    endtask
    task automatic t_nses();
        line(2'h1);
        wr(crs_pkg::OFS_PCGC, 32'h1);
        @(posedge mclk);
        vbus_valid <= 1'b1;
        wsts(crs_pkg::S_NSES, 20, "sts_nses");
        chb("phy_suspend_n", 1'b1, phy_suspend_n);
        wr(crs_pkg::OFS_PCGC, 32'h0);
        wsts(crs_pkg::S_SUSP, 60, "sts_susp");
    endtask
    task automatic t_se0();
        int h;
        h = hs_cnt;
        line(2'h3);
        cyc(tk(100));
        chk("hs_early", 32'(h), 32'(hs_cnt));
        cyc(tk(40));
        chk("hs_pulse", 32'(h + 1), 32'(hs_cnt));
        wsts(crs_pkg::S_BRST, 2, "sts_brst");
        line(2'h1);
        wr(crs_pkg::OFS_STS, 32'hffffffff);
    endtask
    task automatic t_susp();
        wsts(crs_pkg::S_SUSP, 60, "sts_susp");
        wr(crs_pkg::OFS_PCGC, 32'h3);
        chb("bus_clk_en", 1'b0, bus_clk_en);
        line(2'h2);
        cyc(tk(65));
        line(2'h1);
        cyc(4);
        rd(crs_pkg::OFS_STS);
        chb("sts_res_short", 1'b0, rd_v[crs_pkg::S_RES]);
        line(2'h2);
        wsts(crs_pkg::S_RES, 150, "sts_res");
        chb("phy_suspend_n", 1'b1, phy_suspend_n);
        line(2'h1);
        wr(crs_pkg::OFS_PCGC, 32'h0);
        wr(crs_pkg::OFS_STS, 32'hffffffff);
    endtask
    task automatic t_lf();
        wsts(crs_pkg::S_SUSP, 60, "sts_susp");
        wr(crs_pkg::OFS_PCGC, 32'h4);
        wr(crs_pkg::OFS_PCGC, 32'hc);
        wr(crs_pkg::OFS_PCGC, 32'hd);
        wr(crs_pkg::OFS_CFG, CFG0 | 32'h2);
        chb("phy_lf_off", 1'b0, phy_suspend_n);
        line(2'h2);
        cyc(7000);
        rd(crs_pkg::OFS_STS);
        chb("sts_res_lf_early", 1'b0, rd_v[crs_pkg::S_RES]);
        wsts(crs_pkg::S_RES, 6000, "sts_res_lf");
        chb("phy_lf_wake", 1'b1, phy_suspend_n);
        rd(crs_pkg::OFS_CFG);
        chk("cfg_lf", CFG0 | 32'h2, rd_v);
        line(2'h1);
        wr(crs_pkg::OFS_CFG, CFG0);
        wr(crs_pkg::OFS_PCGC, 32'hc);
        wr(crs_pkg::OFS_PCGC, 32'h0);
        wr(crs_pkg::OFS_DCTL, 32'h2);
        rd(crs_pkg::OFS_DCTL);
        chk("dctl_pgdone", 32'h2, rd_v);
    endtask
    task automatic t_rwake();
        wr(crs_pkg::OFS_DCTL, 32'h3);
        chk("k_drive", 32'h7, {29'h0, dp_oe, dm_oe, dm_o | dp_o});
        rd(crs_pkg::OFS_DCTL);
        wr(crs_pkg::OFS_DCTL, rd_v & ~32'h1);
        chb("dp_oe", 1'b0, dp_oe);
        wr(crs_pkg::OFS_STS, 32'hffffffff);
        rd(crs_pkg::OFS_STS);
        chk("sts_clr", 32'h0, rd_v & ~32'h1);
    endtask
    task automatic t_host();
        @(posedge mclk);
        vbus_valid <= 1'b0;
        line(2'h0);
        wr(crs_pkg::OFS_CFG, CFG0 | 32'h1);
        wr(crs_pkg::OFS_STS, 32'hffffffff);
        wr(crs_pkg::OFS_HPRT, 32'h4);
        chb("vbus_drive", 1'b1, vbus_drive);
        line(2'h1);
        wsts(crs_pkg::S_CONN, 40, "sts_conn");
        chk("se0", 32'h4, {29'h0, dp_oe, dp_o, dm_o});
        cyc(tk(30));
        chk("run", 32'h1, {30'h0, dp_oe, sof_en});
        rd(crs_pkg::OFS_LINE);
        chk("line_run", 32'h41, rd_v);
        wr(crs_pkg::OFS_HPRT, 32'h5);
        chb("sof_en", 1'b0, sof_en);
        line(2'h2);
        wsts(crs_pkg::S_RWK, 150, "sts_rwk");
        rd(crs_pkg::OFS_HPRT);
        chb("port_resume", 1'b1, rd_v[crs_pkg::B_PRES]);
        line(2'h1);
        cyc(2);
        chk("k_host", 32'h3, {30'h0, dp_oe, dm_in});
        wr(crs_pkg::OFS_HPRT, 32'h6);
        cyc(100);
        chk("k_held", 32'h3, {30'h0, dp_oe, dm_o});
        wr(crs_pkg::OFS_HPRT, 32'h4);
    endtask
    task automatic t_srp();
        line(2'h0);
        wr(crs_pkg::OFS_HPRT, 32'h5);
        wr(crs_pkg::OFS_HPRT, 32'h1);
        wr(crs_pkg::OFS_PCGC, 32'h4);
        wr(crs_pkg::OFS_PCGC, 32'hc);
        wr(crs_pkg::OFS_PCGC, 32'hd);
        chk("off", 32'h0, {30'h0, vbus_drive, phy_suspend_n});
        line(2'h1);
        wsts(crs_pkg::S_SRP, 40, "sts_srp");
        chb("phy_suspend_n", 1'b1, phy_suspend_n);
        wr(crs_pkg::OFS_PCGC, 32'hc);
        wr(crs_pkg::OFS_PCGC, 32'h8);
        wr(crs_pkg::OFS_PCGC, 32'h0);
        wr(crs_pkg::OFS_HPRT, 32'h4);
        chb("vbus_drive", 1'b1, vbus_drive);
    endtask

    initial begin
        #400000;
        fails++;
        end_of_test();
    end
    initial begin
        cyc(20);
        nrst <= 1'b1;
        @(negedge mclk);
        t_reset();
        t_pcgc();
        t_nses();
        t_se0();
        t_susp();
        t_lf();
        t_rwake();
        t_host();
        t_srp();
        end_of_test();
    end
endmodule
`default_nettype wire
